// ### slave_bus_address_decode.sv
`timescale 1ns/100ps
module slave_bus_address_decode (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Master bus inputs
    input wire logic bus_clk,
    input wire logic [21:0] bus_addr,
    input wire logic s_memr,
    input wire logic s_inp,
    input wire logic s_out,
    input wire logic p_sync,
    input wire logic p_wr_n,
    input wire logic p_dbin,
    input wire logic mwrite,
    input wire logic slave_clr,
    // Master bus outputs
    output logic rdy,
    output logic [7:0] vi_n_out,
    output logic [7:0] vi_n_oe,
    // Slave side
    input wire logic slave_irq,
    input wire logic [11:0] int_io_addr,
    input wire logic int_io_wr,
    input wire logic int_io_wr_early,
    input wire logic timer_tx_clk_a,
    input wire logic timer_rx_clk_a,
    input wire logic timer_tx_clk_b,
    input wire logic timer_rx_clk_b,
    input wire logic conn_tx_clk_a,
    input wire logic conn_rx_clk_a,
    input wire logic conn_tx_clk_b,
    input wire logic conn_rx_clk_b,
    // Decode results
    output logic mem_select,
    output logic port_select,
    output logic [15:0] mem_offset,
    output logic dram_bank,
    output logic int_io_select,
    output logic [8:0] int_io_offset,
    output logic int_io_strobe,
    output logic serial_tx_clk_a,
    output logic serial_rx_clk_a,
    output logic serial_tx_clk_b,
    output logic serial_rx_clk_b
);
    // Bus inputs cross into pclk through two flops each.
    // The write strobe crosses in its active-high sense so that reset leaves it idle.
    localparam int nsync = 31;
    logic [nsync-1:0] raw_in;
    logic [nsync-1:0] sy;
    assign raw_in = {bus_clk, bus_addr, s_memr, s_inp, s_out, p_sync, ~p_wr_n, p_dbin,
        mwrite, slave_clr};

    sync2 #(.width(nsync)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d(raw_in),
        .q(sy)
    );

    logic bclk_s;
    logic [21:0] addr_s;
    logic memr_s;
    logic inp_s;
    logic out_s;
    logic sync_s;
    logic wr_n_s;
    logic wr_s;
    logic dbin_s;
    logic mwrite_s;
    logic clr_s;
    assign {bclk_s, addr_s, memr_s, inp_s, out_s, sync_s, wr_s, dbin_s, mwrite_s, clr_s} = sy;
    assign wr_n_s = ~wr_s;

    logic bclk_rise;
    edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .level(bclk_s),
        .rise(bclk_rise),
        .fall()
    );

    // Configuration and status registers.
    logic [15:0] ctrl_q;
    logic [4:0] page_jumper_q;
    logic [7:0] port_jumper_q;
    logic [4:0] status_q;
    logic [4:0] mask_q;
    logic [15:0] count_q;
    logic ack_q;

    // Jumper fitted reads 0: the stored jumper word is the inverse of the setting.
    logic [4:0] page_setting;
    logic [7:0] port_setting;
    assign page_setting = ~page_jumper_q;
    assign port_setting = ~port_jumper_q;

    // Address compares.
    logic page_match;
    logic range_ok;
    logic mem_cycle;
    logic io_cycle;
    logic port_match;
    logic mem_hit;
    assign page_match = addr_s[slave_decode_pkg::page_msb:slave_decode_pkg::page_lsb]
        == page_setting;
    assign range_ok = ctrl_q[slave_decode_pkg::ctrl_upper] ? addr_s[slave_decode_pkg::range_bit]
        : ~addr_s[slave_decode_pkg::range_bit];
    assign mem_cycle = memr_s | mwrite_s | ~wr_n_s & ~inp_s & ~out_s;
    assign io_cycle = inp_s | out_s;
    assign port_match = io_cycle & (addr_s[7:0] == port_setting);
    assign mem_hit = mem_cycle & page_match & range_ok;
    assign mem_select = mem_hit & ack_q;
    assign port_select = port_match;
    assign mem_offset = addr_s[15:0];

    // Bank select source.
    assign dram_bank = ctrl_q[slave_decode_pkg::ctrl_mem256]
        ? addr_s[slave_decode_pkg::bank_bit_256k]
        : addr_s[slave_decode_pkg::bank_bit_1m];

    // Internal peripheral map.
    function automatic logic in_window(input logic [11:0] a, input logic [11:0] lo,
        input logic [11:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

    logic [11:0] io_base;
    logic [11:0] io_top;
    logic [11:0] io_diff;
    assign io_base = ctrl_q[slave_decode_pkg::ctrl_legacy] ? slave_decode_pkg::io_new_base
        : slave_decode_pkg::io_legacy_base;
    assign io_top = ctrl_q[slave_decode_pkg::ctrl_legacy] ? slave_decode_pkg::io_new_top
        : slave_decode_pkg::io_legacy_top;
    assign io_diff = int_io_addr - io_base;
    assign int_io_select = in_window(int_io_addr, io_base, io_top);
    assign int_io_offset = io_diff[8:0];
    assign int_io_strobe = int_io_select & (ctrl_q[slave_decode_pkg::ctrl_early_wr]
        ? int_io_wr_early : int_io_wr);

    // Baud clock sources; bits select connector per clock.
    logic [3:0] clk_src;
    assign clk_src = ctrl_q[slave_decode_pkg::ctrl_clk_lsb +: 4];
    assign serial_tx_clk_a = clk_src[0] ? conn_tx_clk_a : timer_tx_clk_a;
    assign serial_rx_clk_a = clk_src[1] ? conn_rx_clk_a : timer_rx_clk_a;
    assign serial_tx_clk_b = clk_src[2] ? conn_tx_clk_b : timer_tx_clk_b;
    assign serial_rx_clk_b = clk_src[3] ? conn_rx_clk_b : timer_rx_clk_b;

    // Interrupt routing to a single open-drain vectored line.
    logic [2:0] vi_sel;
    logic irq_sync;
    assign vi_sel = ctrl_q[slave_decode_pkg::ctrl_vi_lsb +: 3];
    sync2 #(.width(1)) u_irq_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d(slave_irq),
        .q(irq_sync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_vi
            assign vi_n_out[gi] = 1'b0;
            assign vi_n_oe[gi] = irq_sync & (vi_sel == 3'(gi));
        end
    endgenerate

    // Wait state: one bus clock of not-ready from pSYNC of a memory access.
    typedef enum logic [1:0] {
        ws_idle = 2'b00,
        ws_hold = 2'b01,
        ws_done = 2'b10
    } ws_state_e;
    ws_state_e ws_q;
    ws_state_e ws_d;
    logic wait_start;
    // Writes raise their strobe only after pSYNC, so the status alone marks a memory cycle here.
    assign wait_start = ctrl_q[slave_decode_pkg::ctrl_wait] & sync_s & ~io_cycle & page_match
        & range_ok & ack_q;
    always_comb begin
        ws_d = ws_q;
        case (ws_q)
            ws_idle: begin
                if (wait_start) begin
                    ws_d = ws_hold;
                end
            end
            ws_hold: begin
                if (bclk_rise) begin
                    ws_d = ws_done;
                end
            end
            ws_done: begin
                if (!sync_s) begin
                    ws_d = ws_idle;
                end
            end
            default: ws_d = ws_idle;
        endcase
    end
    assign rdy = ~(ws_q == ws_hold);

    // Service acknowledge follows the I/O handshake: a master command write to the
    // port confirms, slave clear withdraws it unless ctrl_ack or a confirm in the same cycle sets it.
    logic port_write;
    logic ack_set;
    logic ack_clr;
    assign port_write = port_match & out_s & ~wr_n_s;
    assign ack_set = port_write | ctrl_q[slave_decode_pkg::ctrl_ack];
    assign ack_clr = clr_s;

    // Events and edge detection of them.
    logic mem_ev_lvl;
    logic io_ev_lvl;
    logic ref_ev_lvl;
    logic mem_prev_q;
    logic io_prev_q;
    logic ref_prev_q;
    logic irq_prev_q;
    logic [4:0] ev;
    assign mem_ev_lvl = mem_select;
    assign io_ev_lvl = port_match;
    assign ref_ev_lvl = mem_hit & ~ack_q;
    assign ev[slave_decode_pkg::ev_mem] = mem_ev_lvl & ~mem_prev_q;
    assign ev[slave_decode_pkg::ev_io] = io_ev_lvl & ~io_prev_q;
    assign ev[slave_decode_pkg::ev_refused] = ref_ev_lvl & ~ref_prev_q;
    assign ev[slave_decode_pkg::ev_irq] = irq_sync & ~irq_prev_q;
    assign ev[slave_decode_pkg::ev_count] = bclk_rise & mem_select;

    // APB decode.
    logic acc;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rd_mux;
    assign acc = psel & penable;
    assign wr_en = acc & pwrite & ce;
    assign rd_en = acc & ~pwrite & ce;
    assign hit = (paddr == slave_decode_pkg::addr_ctrl) | (paddr == slave_decode_pkg::addr_page)
        | (paddr == slave_decode_pkg::addr_port) | (paddr == slave_decode_pkg::addr_status)
        | (paddr == slave_decode_pkg::addr_mask) | (paddr == slave_decode_pkg::addr_count);
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    logic status_rd;
    logic rd_setup;
    logic wr_ctrl;
    logic wr_page;
    logic wr_port;
    logic wr_mask;
    assign status_rd = rd_en & (paddr == slave_decode_pkg::addr_status);
    // Read data is latched in the setup phase so that it stands when pready is sampled.
    assign rd_setup = psel & ~penable & ~pwrite & ce;
    assign wr_ctrl = wr_en & (paddr == slave_decode_pkg::addr_ctrl);
    assign wr_page = wr_en & (paddr == slave_decode_pkg::addr_page);
    assign wr_port = wr_en & (paddr == slave_decode_pkg::addr_port);
    assign wr_mask = wr_en & (paddr == slave_decode_pkg::addr_mask);
    always_comb begin
        case (paddr)
            slave_decode_pkg::addr_ctrl: rd_mux = {16'h0000, ctrl_q};
            slave_decode_pkg::addr_page: rd_mux = {27'h0000000, page_setting};
            slave_decode_pkg::addr_port: rd_mux = {24'h000000, port_setting};
            slave_decode_pkg::addr_status: rd_mux = {26'h0000000, ack_q, status_q};
            slave_decode_pkg::addr_mask: rd_mux = {27'h0000000, mask_q};
            slave_decode_pkg::addr_count: rd_mux = {16'h0000, count_q};
            default: rd_mux = 32'h00000000;
        endcase
    end
    assign irq = |(status_q & mask_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= slave_decode_pkg::ctrl_reset;
            page_jumper_q <= ~slave_decode_pkg::page_reset;
            port_jumper_q <= ~slave_decode_pkg::port_reset;
            mask_q <= 5'h00;
            prdata <= 32'h00000000;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[15:0];
            end
            if (wr_page) begin
                page_jumper_q <= ~pwdata[4:0];
            end
            if (wr_port) begin
                port_jumper_q <= ~pwdata[7:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[4:0];
            end
            if (rd_setup) begin
                prdata <= rd_mux;
            end
        end
    end

    // Events win over the clearing read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 5'h00;
        end else if (ce) begin
            // Only the bits handed out by the read are cleared, so a later event is kept.
            status_q <= (status_rd ? status_q & ~prdata[4:0] : status_q) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
            ws_q <= ws_idle;
            mem_prev_q <= 1'b0;
            io_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
            irq_prev_q <= 1'b0;
            count_q <= 16'h0000;
        end else if (ce) begin
            ack_q <= ack_set | (ack_q & ~ack_clr);
            ws_q <= ws_d;
            mem_prev_q <= mem_ev_lvl;
            io_prev_q <= io_ev_lvl;
            ref_prev_q <= ref_ev_lvl;
            irq_prev_q <= irq_sync;
            if (ev[slave_decode_pkg::ev_count]) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule // slave_bus_address_decode

// ### slave_decode_pkg.sv
// Behaviour
// - Match master address bits 16..20 against the page setting to select memory.
// - Memory cycles reach slave memory only after an acknowledged service request.
// - Each compare setting bit reads 0 with jumper fitted, 1 when absent.
// - Extended page setting defaults to 10H.
// - Match address bits 0..7 against the port setting in I/O cycles.
// - I/O port setting defaults to 3FH.
// - Internal peripherals decode at 000H-120H, or 400H-520H with option fitted.
// - Internal write strobe uses normal write; option selects early write.
// - Optional single wait state on ready during pSYNC of memory accesses.
// - DRAM bank select from address bit 19; option serves 256K population.
// - Slave interrupt routes to exactly one of eight vectored lines.
// - Upper-range option: respond to memory only while A21 is high.
// - Baud clocks from timer by default; connector sources, tx and rx separate.
// - Address bits 0..15 select a location in the mapped 64K window.
package slave_decode_pkg;
    localparam logic [4:0] page_reset = 5'h10;
    localparam logic [7:0] port_reset = 8'h3f;
    localparam logic [11:0] io_legacy_base = 12'h000;
    localparam logic [11:0] io_legacy_top = 12'h120;
    localparam logic [11:0] io_new_base = 12'h400;
    localparam logic [11:0] io_new_top = 12'h520;
    localparam int page_msb = 20;
    localparam int page_lsb = 16;
    localparam int range_bit = 21;
    localparam int bank_bit_1m = 19;
    localparam int bank_bit_256k = 17;
    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_page = 8'h04;
    localparam logic [7:0] addr_port = 8'h08;
    localparam logic [7:0] addr_status = 8'h0c;
    localparam logic [7:0] addr_mask = 8'h10;
    localparam logic [7:0] addr_count = 8'h14;
    localparam int ctrl_legacy = 0;
    localparam int ctrl_early_wr = 1;
    localparam int ctrl_wait = 2;
    localparam int ctrl_mem256 = 3;
    localparam int ctrl_upper = 4;
    localparam int ctrl_ack = 5;
    localparam int ctrl_vi_lsb = 8;
    localparam int ctrl_clk_lsb = 12;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    localparam int ev_mem = 0;
    localparam int ev_io = 1;
    localparam int ev_refused = 2;
    localparam int ev_irq = 3;
    localparam int ev_count = 4;
endpackage

// ### sync2.sv
`timescale 1ns/100ps
module sync2 #(
    parameter int width = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Data
    input wire logic [width-1:0] d,
    output logic [width-1:0] q
);
    logic [width-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync2

// ### edge_detect.sv
`timescale 1ns/100ps
module edge_detect (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Level in, edge pulses out
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= level;
        end
    end
    assign rise = ce & level & ~prev_q;
    assign fall = ce & ~level & prev_q;
endmodule // edge_detect

// ### slave_decode_assertions.sv
`timescale 1ns/100ps
module slave_decode_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Master bus
    input wire logic [21:0] bus_addr,
    input wire logic s_inp,
    input wire logic s_out,
    input wire logic rdy,
    input wire logic [7:0] vi_n_out,
    input wire logic [7:0] vi_n_oe,
    // Slave side
    input wire logic [11:0] int_io_addr,
    input wire logic int_io_wr,
    input wire logic int_io_wr_early,
    input wire logic timer_tx_clk_a,
    input wire logic conn_tx_clk_a,
    // Decode results
    input wire logic mem_select,
    input wire logic port_select,
    input wire logic [15:0] mem_offset,
    input wire logic dram_bank,
    input wire logic int_io_select,
    input wire logic [8:0] int_io_offset,
    input wire logic int_io_strobe,
    input wire logic serial_tx_clk_a
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mem_offset: assert property (mem_select |-> mem_offset == $past(bus_addr[15:0], 2))
        else $error("memory offset does not follow the address");
    a_bank_source: assert property (mem_select |-> dram_bank == $past(bus_addr[19], 2)
        || dram_bank == $past(bus_addr[17], 2)) else $error("bank select source wrong");
    a_port_cycle: assert property (port_select |-> $past(s_inp, 2) || $past(s_out, 2))
        else $error("port select outside an I/O cycle");
    a_vi_single: assert property ($onehot0(vi_n_oe) && vi_n_out == 8'h00)
        else $error("more than one interrupt line driven");
    a_io_window: assert property (int_io_select |-> int_io_offset == int_io_addr[8:0]
        && (int_io_addr <= 12'h120 || (int_io_addr >= 12'h400 && int_io_addr <= 12'h520)))
        else $error("internal select outside its window");
    a_strobe_cause: assert property (int_io_strobe |-> int_io_wr || int_io_wr_early)
        else $error("strobe without a write");
    a_wait_single: assert property (!rdy |-> ##[1:16] rdy)
        else $error("wait state too long");
    a_clock_mux: assert property (serial_tx_clk_a == timer_tx_clk_a
        || serial_tx_clk_a == conn_tx_clk_a) else $error("serial clock from no source");
endmodule // slave_decode_assertions

// ### bus_master_model.sv
`timescale 1ns/100ps
module bus_master_model (
    // Slave handshake
    input wire logic rdy,
    // Master outputs
    output logic bus_clk,
    output logic [21:0] bus_addr,
    output logic s_memr,
    output logic s_inp,
    output logic s_out,
    output logic p_sync,
    output logic p_wr_n,
    output logic p_dbin,
    output logic mwrite,
    output logic slave_clr
);
    initial begin
        {bus_clk, bus_addr, s_memr, s_inp, s_out, p_sync, p_dbin, mwrite, slave_clr} = '0;
        p_wr_n = 1'b1;
        #7;
        forever #200 bus_clk = ~bus_clk;
    end
    // Status and address with the sync pulse, then the strobe, stretched while rdy is low.
    task automatic cycle(input logic [21:0] a, input logic mem, input logic wr);
        @(posedge bus_clk);
        bus_addr <= a;
        {s_memr, s_inp, s_out} <= {mem & !wr, !mem & !wr, !mem & wr};
        p_sync <= 1'b1;
        @(posedge bus_clk);
        p_sync <= 1'b0;
        {p_wr_n, mwrite, p_dbin} <= {!wr, mem & wr, !wr};
        @(posedge bus_clk);
        while (rdy !== 1'b1) @(posedge bus_clk);
        {s_memr, s_inp, s_out, mwrite, p_dbin} <= '0;
        p_wr_n <= 1'b1;
        // A released address no longer shows the last value.
        bus_addr <= ~a;
    endtask
    task automatic clear();
        @(posedge bus_clk);
        slave_clr <= 1'b1;
        @(posedge bus_clk);
        slave_clr <= 1'b0;
    endtask
endmodule // bus_master_model

// ### test_slave_bus_address_decode.sv
`timescale 1ns/100ps
module test_slave_bus_address_decode;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, bus_clk, err;
    logic [7:0] paddr, vi_n_out, vi_n_oe;
    logic [31:0] pwdata, prdata, rd;
    logic [21:0] bus_addr;
    logic s_memr, s_inp, s_out, p_sync, p_wr_n, p_dbin, mwrite, slave_clr, rdy, slave_irq;
    logic [11:0] int_io_addr;
    logic int_io_wr, int_io_wr_early, mem_select, port_select, dram_bank, int_io_select;
    logic int_io_strobe, seen_mem, seen_port, seen_wait, bank_q;
    // Serial clocks in the order tx A, rx A, tx B, rx B.
    logic [3:0] tmr, conn, ser;
    logic [15:0] mem_offset, off_q;
    logic [8:0] int_io_offset;
    logic [11:0] ioa [6] = '{12'h000, 12'h120, 12'h121, 12'h400, 12'h520, 12'h521};
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    slave_bus_address_decode uut (.*, .timer_tx_clk_a(tmr[0]), .timer_rx_clk_a(tmr[1]),
        .timer_tx_clk_b(tmr[2]), .timer_rx_clk_b(tmr[3]), .conn_tx_clk_a(conn[0]),
        .conn_rx_clk_a(conn[1]), .conn_tx_clk_b(conn[2]), .conn_rx_clk_b(conn[3]),
        .serial_tx_clk_a(ser[0]), .serial_rx_clk_a(ser[1]), .serial_tx_clk_b(ser[2]),
        .serial_rx_clk_b(ser[3]));
    bus_master_model master (.*);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (mem_select === 1'b1) begin
            seen_mem = 1'b1;
            bank_q = dram_bank;
            off_q = mem_offset;
        end
        if (port_select === 1'b1) seen_port = 1'b1;
        if (rdy === 1'b0) seen_wait = 1'b1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task mem_try(input logic [21:0] a, input logic sel, input logic bank, input logic w);
        {seen_mem, seen_wait} = 2'b00;
        master.cycle(a, 1'b1, a[0]);
        repeat (3) @(posedge pclk);
        chk(seen_mem, sel);
        chk(seen_wait, w);
        if (sel) chk(bank_q, bank);
        if (sel) chk(off_q, a[15:0]);
    endtask
    task t_defaults();
        apb(slave_decode_pkg::addr_page, 1'b0, 32'h0);
        chk(rd, 32'h10);
        apb(slave_decode_pkg::addr_port, 1'b0, 32'h0);
        chk(rd, 32'h3f);
        apb(8'h40, 1'b0, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask
    task t_access();
        mem_try(22'h101234, 1'b0, 1'b0, 1'b0);
        apb(slave_decode_pkg::addr_status, 1'b0, 32'h0);
        chk(rd[2], 1'b1);
        seen_port = 1'b0;
        master.cycle(22'h00003e, 1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        chk(seen_port, 1'b0);
        master.cycle(22'h00003f, 1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        chk(seen_port, 1'b1);
        apb(slave_decode_pkg::addr_page, 1'b1, 32'h08);
        mem_try(22'h08abcd, 1'b1, 1'b1, 1'b0);
        mem_try(22'h09abcd, 1'b0, 1'b0, 1'b0);
        mem_try(22'h28abcd, 1'b0, 1'b0, 1'b0);
        apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'h0c);
        mem_try(22'h080001, 1'b1, 1'b0, 1'b1);
        apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'h10);
        mem_try(22'h08abcd, 1'b0, 1'b0, 1'b0);
        mem_try(22'h28abcd, 1'b1, 1'b1, 1'b0);
        master.clear();
        mem_try(22'h28abcd, 1'b0, 1'b0, 1'b0);
    endtask
    task t_irq();
        apb(slave_decode_pkg::addr_mask, 1'b1, 32'h08);
        for (int i = 0; i < 8; i++) begin
            apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'(i) << 8);
            slave_irq <= 1'b1;
            repeat (4) @(posedge pclk);
            chk({irq, vi_n_oe}, {1'b1, 8'h01 << i});
            slave_irq <= 1'b0;
            apb(slave_decode_pkg::addr_status, 1'b0, 32'h0);
            repeat (3) @(posedge pclk);
            chk({irq, vi_n_oe}, 9'h000);
        end
    endtask
    task t_local();
        for (int m = 0; m < 2; m++) begin
            apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'(m));
            foreach (ioa[i]) begin
                int_io_addr <= ioa[i];
                @(posedge pclk);
                @(posedge pclk);
                chk(int_io_select, m ? ioa[i] >= 12'h400 && ioa[i] <= 12'h520
                    : ioa[i] <= 12'h120);
                if (int_io_select === 1'b1)
                    chk(int_io_offset, ioa[i] - (m ? 12'h400 : 12'h000));
            end
        end
        {int_io_addr, int_io_wr, int_io_wr_early} <= {12'h400, 2'b10};
        apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'h01);
        chk(int_io_strobe, 1'b1);
        apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'h03);
        chk(int_io_strobe, 1'b0);
        int_io_wr_early <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        chk(int_io_strobe, 1'b1);
        {tmr, conn} <= 8'hf0;
        for (int k = 0; k < 4; k++) begin
            apb(slave_decode_pkg::addr_ctrl, 1'b1, 32'h1000 << k);
            chk(ser, 4'hf & ~(4'h1 << k));
        end
    endtask
    initial begin
        {ce, presetn, psel, penable, pwrite, slave_irq, int_io_wr, int_io_wr_early} = 8'h80;
        {paddr, pwdata, int_io_addr, tmr, conn} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_access();
        t_irq();
        t_local();
        conclude();
    end
endmodule // test_slave_bus_address_decode
bind slave_bus_address_decode slave_decode_assertions watch (.*);
